// [rtl/ubm_pkg.sv]
// Package: constants and types for the serial port baud and mode 0/1 logic
package ubm_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned M0_DIV         = 12;
  // Mode 2 sixteenth-of-bit divides: a bit lasts 64 clocks, or 32 when doubled
  localparam logic [6:0]  M2_DIV_SLOW    = 7'h03;
  localparam logic [6:0]  M2_DIV_FAST    = 7'h01;
  localparam logic [3:0]  OVS_LAST       = 4'hf;
  localparam logic [3:0]  VOTE_A         = 4'h7;
  localparam logic [3:0]  VOTE_B         = 4'h8;
  localparam logic [3:0]  VOTE_C         = 4'h9;
  localparam logic [8:0]  RX1_INIT       = 9'h1ff;
  localparam logic [7:0]  RX0_INIT       = 8'hfe;
  localparam logic [3:0]  M1_TX_SHIFTS   = 4'ha;
  localparam logic [1:0]  MODE_SHIFT     = 2'h0;
  localparam logic [1:0]  MODE_ASYNC8    = 2'h1;
  localparam logic [1:0]  MODE_FIXED9    = 2'h2;
  localparam logic [1:0]  MODE_VAR9      = 2'h3;

  typedef struct packed {
    logic       mode_select_hi;
    logic       mode_select_lo;
    logic       selective_rx_gate;
    logic       rx_allow;
    logic       baud_doubler;
    logic       rx_clock_select;
    logic       tx_clock_select;
  } ubm_ctrl_t;

  typedef enum logic [1:0] {
    UBM_TX_IDLE  = 2'b00,
    UBM_TX_WAIT  = 2'b01,
    UBM_TX_START = 2'b11,
    UBM_TX_DATA  = 2'b10
  } ubm_tx_st_t;

  typedef enum logic [1:0] {
    UBM_RX_HUNT  = 2'b00,
    UBM_RX_ARM   = 2'b01,
    UBM_RX_BITS  = 2'b11,
    UBM_RX_DONE  = 2'b10
  } ubm_rx_st_t;
endpackage

// [rtl/ubm_uart.sv]
// Serial port: baud selection for four modes, mode 0 and mode 1 sequencing
`timescale 1ns/1ps
`default_nettype none
module ubm_uart #(
  parameter int unsigned MACH_CYC = 12
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rstn_i,
  input  wire ubm_pkg::ubm_ctrl_t ctrl_i,
  input  wire logic             t1_ovf_i,
  input  wire logic             t2_ovf_i,
  input  wire logic             buf_wr_i,
  input  wire logic [7:0]       buf_wdata_i,
  input  wire logic             tx_done_clr_i,
  input  wire logic             rx_done_clr_i,
  input  wire logic             rxd_pin_i,
  output logic                  rxd_pin_o,
  output logic                  rxd_pin_oe_n_o,
  output logic                  txd_pin_o,
  output logic [7:0]            line_buffer_o,
  output logic                  rx_ninth_bit_o,
  output logic                  tx_done_flag_o,
  output logic                  rx_done_flag_o,
  output logic                  tx_active_o,
  output logic                  rx_active_o
);
  // Pin synchroniser; first stage feeds only the second
  logic       rxd_s1_r;
  logic       rxd_s2_r;
  logic       rxd_prev_r;
  logic [3:0] mcyc_r;
  logic       half_r;
  logic [6:0] m2_cnt_r;
  logic [3:0] ovs_r;
  logic [3:0] tx_sub_r;
  logic [8:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_sub_r;
  logic [2:0] vote_r;
  logic       sclk_r;
  logic       txd_r;
  logic       rxo_r;
  logic       rxoe_n_r;
  logic [7:0] lbuf_r;
  logic       rb8_r;
  logic       tdf_r;
  logic       rdf_r;
  ubm_pkg::ubm_tx_st_t tx_st_r;
  ubm_pkg::ubm_rx_st_t rx_st_r;

  wire [1:0] mode    = {ctrl_i.mode_select_hi, ctrl_i.mode_select_lo};
  wire       is_m0   = (mode == ubm_pkg::MODE_SHIFT);
  wire       is_m1   = (mode == ubm_pkg::MODE_ASYNC8);
  wire       mcyc_end = (mcyc_r == 4'(MACH_CYC - 1));
  // Mode 0 shift clock: one machine cycle per bit, low in first half
  wire       sclk_fall = mcyc_end;
  wire       sclk_rise = (mcyc_r == 4'(MACH_CYC / 2 - 1));
  // Timer 1 when both selects are 0, otherwise timer 2 feeds the rate
  wire       use_t2   = ctrl_i.tx_clock_select | ctrl_i.rx_clock_select;
  wire       ovf      = use_t2 ? t2_ovf_i : t1_ovf_i;
  wire       var_tick = ctrl_i.baud_doubler ? ovf : (ovf & half_r);
  wire       m2_tick  = (m2_cnt_r == (ctrl_i.baud_doubler ? ubm_pkg::M2_DIV_FAST
                                                          : ubm_pkg::M2_DIV_SLOW));
  // Sixteenth-of-bit tick for the asynchronous modes
  wire       ovs_tick = mode[1] & ~mode[0] ? m2_tick : var_tick;
  wire       tx_roll  = ovs_tick && (tx_sub_r == ubm_pkg::OVS_LAST);
  wire       fall     = rxd_prev_r & ~rxd_s2_r;
  wire       vote     = (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2])
                        | (vote_r[1] & vote_r[2]);
  wire       rx_bit_end = ovs_tick && (rx_sub_r == ubm_pkg::OVS_LAST);
  wire       rx_ok    = ~rdf_r & (~ctrl_i.selective_rx_gate | vote);
  // Mode 0 receive arms at a machine-cycle end once the flag is clear
  wire       m0_rx_go = is_m0 && ctrl_i.rx_allow && !rdf_r && mcyc_end
                        && (rx_st_r == ubm_pkg::UBM_RX_HUNT);
  // Shift clock falls only while a mode 0 transfer is armed or running;
  // the first fall coincides with the start, so no bit moves unclocked
  wire       m0_clk_go = is_m0 && sclk_fall
                         && ((tx_st_r == ubm_pkg::UBM_TX_WAIT)
                             || (tx_st_r == ubm_pkg::UBM_TX_DATA)
                             || (rx_st_r == ubm_pkg::UBM_RX_ARM) || m0_rx_go);
  // Receive registers fill from the right, so the first bit ends on the left;
  // reverse on load to hand the byte over least significant bit first
  wire [7:0] m0_fill  = {rx_sh_r[6:0], rxd_s2_r};
  logic [7:0] m0_rev;
  logic [7:0] m1_rev;
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_rev
    assign m0_rev[gi] = m0_fill[7 - gi];
    assign m1_rev[gi] = rx_sh_r[7 - gi];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      rxd_s1_r   <= 1'b1;
      rxd_s2_r   <= 1'b1;
      rxd_prev_r <= 1'b1;
      mcyc_r     <= 4'h0;
      half_r     <= 1'b0;
      m2_cnt_r   <= 7'h00;
      tx_sub_r   <= 4'h0;
    end
    else
    begin
      rxd_s1_r   <= rxd_pin_i;
      rxd_s2_r   <= rxd_s1_r;
      rxd_prev_r <= rxd_s2_r;
      mcyc_r     <= mcyc_end ? 4'h0 : mcyc_r + 4'h1;
      if (ovf)
        half_r   <= ~half_r;
      m2_cnt_r   <= m2_tick ? 7'h00 : m2_cnt_r + 7'h01;
      if (ovs_tick)
        tx_sub_r <= tx_sub_r + 4'h1;
    end
  end

  // Transmit sequencer, both modes
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      tx_st_r   <= ubm_pkg::UBM_TX_IDLE;
      tx_sh_r   <= 9'h000;
      tx_bits_r <= 4'h0;
      txd_r     <= 1'b1;
      sclk_r    <= 1'b1;
      tdf_r     <= 1'b0;
    end
    else
    begin
      // Set wins over a software clear in the same cycle
      if (tx_done_clr_i)
        tdf_r <= 1'b0;
      // Clock rests high between transfers; a partner may key on its edges
      if (m0_clk_go)
        sclk_r <= 1'b0;
      else if (sclk_rise)
        sclk_r <= 1'b1;
      case (tx_st_r)
        ubm_pkg::UBM_TX_IDLE:
        begin
          if (buf_wr_i)
          begin
            tx_sh_r <= {1'b1, buf_wdata_i};
            tx_st_r <= ubm_pkg::UBM_TX_WAIT;
          end
        end
        ubm_pkg::UBM_TX_WAIT:
        begin
          if (is_m0 && mcyc_end)
          begin
            tx_st_r <= ubm_pkg::UBM_TX_DATA;
          end
          else if (!is_m0 && tx_roll)
          begin
            txd_r     <= 1'b0;
            tx_bits_r <= 4'h1;
            tx_st_r   <= ubm_pkg::UBM_TX_START;
          end
        end
        ubm_pkg::UBM_TX_START:
        begin
          if (tx_roll)
          begin
            txd_r     <= tx_sh_r[0];
            tx_bits_r <= tx_bits_r + 4'h1;
            tx_st_r   <= ubm_pkg::UBM_TX_DATA;
          end
        end
        ubm_pkg::UBM_TX_DATA:
        begin
          if (is_m0)
          begin
            // Shift on the rising clock, after the partner took the bit low
            if (sclk_rise)
            begin
              tx_sh_r <= {1'b0, tx_sh_r[8:1]};
              if (tx_sh_r[8:1] == 8'h01)
              begin
                tdf_r   <= 1'b1;
                tx_st_r <= ubm_pkg::UBM_TX_IDLE;
              end
            end
          end
          else if (tx_roll)
          begin
            tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
            txd_r     <= tx_sh_r[1];
            tx_bits_r <= tx_bits_r + 4'h1;
            // Marker next to MSB: stop bit out, done at tenth rollover
            // Counter holds rollovers already seen, so this is the tenth
            if ((tx_bits_r + 4'h1) == ubm_pkg::M1_TX_SHIFTS)
            begin
              txd_r   <= 1'b1;
              tdf_r   <= 1'b1;
              tx_st_r <= ubm_pkg::UBM_TX_IDLE;
            end
          end
        end
        default:
          tx_st_r <= ubm_pkg::UBM_TX_IDLE;
      endcase
    end
  end

  // Receive sequencer, both modes
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      rx_st_r  <= ubm_pkg::UBM_RX_HUNT;
      rx_sh_r  <= 9'h000;
      rx_sub_r <= 4'h0;
      vote_r   <= 3'h0;
      lbuf_r   <= 8'h00;
      rb8_r    <= 1'b0;
      rdf_r    <= 1'b0;
    end
    else
    begin
      if (rx_done_clr_i)
        rdf_r <= 1'b0;
      case (rx_st_r)
        ubm_pkg::UBM_RX_HUNT:
        begin
          if (is_m0 && ctrl_i.rx_allow && !rdf_r && mcyc_end)
          begin
            rx_sh_r <= {1'b1, ubm_pkg::RX0_INIT};
            rx_st_r <= ubm_pkg::UBM_RX_ARM;
          end
          else if (!is_m0 && ctrl_i.rx_allow && fall)
          begin
            rx_sub_r <= 4'h0;
            rx_sh_r  <= ubm_pkg::RX1_INIT;
            rx_st_r  <= ubm_pkg::UBM_RX_BITS;
          end
        end
        ubm_pkg::UBM_RX_ARM:
        begin
          // Shift clock enabled; sample on rising edge of the shift clock
          if (sclk_rise)
          begin
            rx_sh_r <= {rx_sh_r[7:0], rxd_s2_r};
            if (!rx_sh_r[7])
            begin
              lbuf_r  <= m0_rev;
              rdf_r   <= 1'b1;
              rx_st_r <= ubm_pkg::UBM_RX_HUNT;
            end
          end
        end
        ubm_pkg::UBM_RX_BITS:
        begin
          if (ovs_tick)
          begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == ubm_pkg::VOTE_A || rx_sub_r == ubm_pkg::VOTE_B
                || rx_sub_r == ubm_pkg::VOTE_C)
              vote_r <= {vote_r[1:0], rxd_s2_r};
          end
          if (rx_bit_end)
          begin
            rx_sh_r <= {rx_sh_r[7:0], vote};
            if (rx_sh_r == ubm_pkg::RX1_INIT && vote)
              rx_st_r <= ubm_pkg::UBM_RX_HUNT;
            else if (!rx_sh_r[8])
            begin
              // Final shift: vote is the stop bit
              if (rx_ok)
              begin
                lbuf_r <= m1_rev;
                rb8_r  <= vote;
                rdf_r  <= 1'b1;
              end
              rx_st_r <= ubm_pkg::UBM_RX_DONE;
            end
          end
        end
        ubm_pkg::UBM_RX_DONE:
          rx_st_r <= ubm_pkg::UBM_RX_HUNT;
        default:
          rx_st_r <= ubm_pkg::UBM_RX_HUNT;
      endcase
    end
  end

  // Pin outputs: mode 0 uses the input-line pin as data out while sending
  wire m0_tx = is_m0 && (tx_st_r == ubm_pkg::UBM_TX_DATA);
  wire m0_rx = is_m0 && (rx_st_r == ubm_pkg::UBM_RX_ARM);
  // Enable the data pin with the first clock fall, not a cycle after it
  wire m0_tx_go = is_m0 && mcyc_end && (tx_st_r == ubm_pkg::UBM_TX_WAIT);
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      rxo_r    <= 1'b1;
      rxoe_n_r <= 1'b1;
    end
    else
    begin
      rxo_r    <= tx_sh_r[0];
      rxoe_n_r <= ~(m0_tx | m0_tx_go);
    end
  end

  assign rxd_pin_o      = rxo_r;
  assign rxd_pin_oe_n_o = rxoe_n_r;
  assign txd_pin_o      = (m0_tx | m0_rx) ? sclk_r : (is_m0 ? 1'b1 : txd_r);
  assign line_buffer_o  = lbuf_r;
  assign rx_ninth_bit_o = rb8_r;
  assign tx_done_flag_o = tdf_r;
  assign rx_done_flag_o = rdf_r;
  assign tx_active_o    = (tx_st_r == ubm_pkg::UBM_TX_DATA) | (tx_st_r == ubm_pkg::UBM_TX_START);
  assign rx_active_o    = (rx_st_r == ubm_pkg::UBM_RX_ARM) | (rx_st_r == ubm_pkg::UBM_RX_BITS);
  wire unused_ok = is_m1 | (mode == ubm_pkg::MODE_VAR9);
endmodule
`default_nettype wire

// [dv/ubm_props.sv]
// Checker: timing relations at the serial port block's pins
`timescale 1ns/1ps
`default_nettype none
module ubm_props (
  input wire logic               sys_clk_i,
  input wire logic               rstn_i,
  input wire ubm_pkg::ubm_ctrl_t ctrl_i,
  input wire logic               tx_done_clr_i,
  input wire logic               rx_done_clr_i,
  input wire logic               rxd_pin_oe_n_o,
  input wire logic               txd_pin_o,
  input wire logic [7:0]         line_buffer_o,
  input wire logic               tx_done_flag_o,
  input wire logic               rx_done_flag_o,
  input wire logic               tx_active_o,
  input wire logic               rx_active_o
);
  wire logic [1:0] mode = {ctrl_i.mode_select_hi, ctrl_i.mode_select_lo};
  wire logic       m0   = (mode == ubm_pkg::MODE_SHIFT);
  wire logic       m1   = (mode == ubm_pkg::MODE_ASYNC8);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_m0_clk_shape: assert property (m0 && $fell(txd_pin_o) |-> !txd_pin_o [*6] ##1 txd_pin_o)
    else $error("Shift clock low phase wrong");
  a_m0_send_drive: assert property (m0 && tx_active_o && $fell(txd_pin_o) |-> !rxd_pin_oe_n_o)
    else $error("Data pin not driven during send");
  a_m0_rx_release: assert property (m0 && rx_active_o |-> rxd_pin_oe_n_o)
    else $error("Data pin driven during receive");
  a_tx_end_flag: assert property ($fell(tx_active_o) |-> ##[0:1] tx_done_flag_o)
    else $error("Send ended without done flag");
  a_tx_flag_hold: assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o)
    else $error("Send flag dropped by itself");
  a_rx_flag_hold: assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
    else $error("Receive flag dropped by itself");
  a_m1_start_bit: assert property (m1 && $rose(tx_active_o) |-> !txd_pin_o [*8])
    else $error("Start bit missing or short");
  a_buf_on_done: assert property ($changed(line_buffer_o) |-> ##[0:1] rx_done_flag_o)
    else $error("Buffer changed without receive flag");
  a_buf_locked: assert property (rx_done_flag_o && $past(rx_done_flag_o) &&
    $past(rx_done_flag_o, 2) |-> $stable(line_buffer_o))
    else $error("Buffer overwritten while flag set");
endmodule
`default_nettype wire

// [dv/ubm_peer.sv]
// Remote serial partner: mode 1 line driver and decoder, mode 0 shift peripheral
`timescale 1ns/1ps
`default_nettype none
module ubm_peer (
  input  wire logic clk,
  input  wire logic sync_mode,
  input  wire logic txd,
  input  wire logic pin,
  output logic      rxd
);
  int         bit_cyc = 64;
  logic [7:0] feed    = 8'hff;
  logic [9:0] frm;
  logic       fq[$];
  logic [9:0] tq[$];
  initial rxd = 1'b1;
  task automatic drive(input logic v, input int n);
    rxd = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Mid-bit sampling; edges inside a busy frame are ignored
  always @(negedge txd)
    if (!sync_mode)
    begin
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
        frm[i] = txd;
        if (i < 9)
          repeat (bit_cyc) @(posedge clk);
      end
      tq.push_back(frm);
    end
  // New bit after the clock falls, capture in the low phase; ones act as pull-up
  always @(negedge txd)
    if (sync_mode)
    begin
      #1 rxd = feed[0];
      feed = {1'b1, feed[7:1]};
      repeat (3) @(posedge clk);
      fq.push_back(pin);
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Testbench: mode 0 and mode 1 transfers checked against a queue model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               sys_clk_i     = 1'b0;
  logic               rstn_i        = 1'b0;
  ubm_pkg::ubm_ctrl_t ctrl_i        = '0;
  logic               t1_ovf_i      = 1'b0;
  logic               buf_wr_i      = 1'b0;
  logic [7:0]         buf_wdata_i   = 8'h00;
  logic               tx_done_clr_i = 1'b0;
  logic               rx_done_clr_i = 1'b0;
  wire logic          rxd_pin_o, rxd_pin_oe_n_o, txd_pin_o, rx_ninth_bit_o, peer_rxd;
  wire logic          tx_done_flag_o, rx_done_flag_o, tx_active_o, rx_active_o;
  wire logic [7:0]    line_buffer_o;
  wire logic          rxd_w = rxd_pin_oe_n_o ? peer_rxd : rxd_pin_o;
  wire logic          m0 = ({ctrl_i.mode_select_hi, ctrl_i.mode_select_lo} == 2'h0);
  int                 mismatches = 0;
  int                 cmp_count  = 0;
  int                 cyc        = 0;
  logic [7:0]         exp_q[$];
  logic [8:0]         eb = 9'h000;
  logic [7:0]         d;
  logic               rf = 1'b0;
  logic               g, stp;
  ubm_uart dut (.sys_clk_i, .rstn_i, .ctrl_i, .t1_ovf_i, .t2_ovf_i(1'b0), .buf_wr_i,
    .buf_wdata_i, .tx_done_clr_i, .rx_done_clr_i, .rxd_pin_i(rxd_w), .rxd_pin_o,
    .rxd_pin_oe_n_o, .txd_pin_o, .line_buffer_o, .rx_ninth_bit_o, .tx_done_flag_o,
    .rx_done_flag_o, .tx_active_o, .rx_active_o);
  ubm_peer peer (.clk(sys_clk_i), .sync_mode(m0), .txd(txd_pin_o), .pin(rxd_w), .rxd(peer_rxd));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  // Timer overflow every 4 clocks; one bit is 64 clocks doubled, 128 plain
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    t1_ovf_i <= (cyc % 4 == 3);
    if (cyc == 30000)
    begin
      mismatches++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    buf_wdata_i = v;
    buf_wr_i = 1'b1;
    tick(1);
    buf_wr_i = 1'b0;
  endtask
  task automatic clr(input logic t, input logic r);
    tx_done_clr_i = t;
    rx_done_clr_i = r;
    tick(1);
    tx_done_clr_i = 1'b0;
    rx_done_clr_i = 1'b0;
  endtask
  // A short low glitch first, then a whole frame and two idle bits
  task automatic send(input logic [7:0] v, input logic s);
    logic [9:0] f;
    f = {s, v, 1'b0};
    peer.drive(1'b0, 4);
    peer.drive(1'b1, 2 * peer.bit_cyc);
    for (int i = 0; i < 10; i++)
      peer.drive(f[i], peer.bit_cyc);
    peer.drive(1'b1, 2 * peer.bit_cyc);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'ha655e4fb));
    tick(20);
    rstn_i = 1'b1;
    chk("reset", {tx_done_flag_o, txd_pin_o, line_buffer_o}, 10'h100);
    ctrl_i.mode_select_lo = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ctrl_i.baud_doubler = (k < 3);
      peer.bit_cyc = (k < 3) ? 64 : 128;
      d = 8'($urandom);
      exp_q.push_back(d);
      wr(d);
      wait (tx_active_o === 1'b1);
      tick(40);
      wr(~d);
      wait (tx_done_flag_o === 1'b1);
      tick(2 * peer.bit_cyc);
      chk("m1 frame", peer.tq.pop_front(), {1'b1, exp_q.pop_front(), 1'b0});
      chk("m1 busy", tx_active_o, 10'h0);
      clr(1'b1, 1'b0);
    end
    $display("test m1_tx done");
    ctrl_i.mode_select_hi = 1'b1;
    ctrl_i.mode_select_lo = 1'b0;
    ctrl_i.baud_doubler = 1'b0;
    peer.bit_cyc = 64;
    d = 8'($urandom);
    wr(d);
    wait (tx_done_flag_o === 1'b1);
    tick(2 * peer.bit_cyc);
    chk("m2 frame", peer.tq.pop_front(), {1'b1, d, 1'b0});
    clr(1'b1, 1'b0);
    ctrl_i.mode_select_hi = 1'b0;
    ctrl_i.mode_select_lo = 1'b1;
    $display("test m2_tx done");
    ctrl_i.baud_doubler = 1'b1;
    peer.bit_cyc = 64;
    ctrl_i.rx_allow = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      d = 8'($urandom);
      g = (k == 2 || k == 3);
      stp = (k != 1 && k != 2);
      ctrl_i.selective_rx_gate = g;
      send(d, stp);
      if (!rf && (!g || stp))
        eb = {stp, d};
      rf = rf || !g || stp;
      chk("m1 rx buf", {rx_ninth_bit_o, line_buffer_o}, eb);
      chk("m1 rx flag", rx_done_flag_o, rf);
      if (k != 3)
        clr(1'b0, 1'b1);
      rf = rf && (k == 3);
    end
    $display("test m1_rx done");
    ctrl_i.rx_allow = 1'b0;
    ctrl_i.mode_select_lo = 1'b0;
    tick(4);
    d = 8'($urandom);
    peer.fq.delete();
    wr(d);
    wait (tx_done_flag_o === 1'b1);
    tick(12);
    for (int i = 0; i < 8; i++)
      chk("m0 tx bit", peer.fq[i], d[i]);
    chk("m0 tx clocks", 10'(peer.fq.size()), 10'd8);
    clr(1'b1, 1'b0);
    $display("test m0_tx done");
    d = 8'($urandom);
    peer.feed = d;
    ctrl_i.rx_allow = 1'b1;
    wait (rx_done_flag_o === 1'b1);
    tick(2);
    ctrl_i.rx_allow = 1'b0;
    chk("m0 rx buf", line_buffer_o, d);
    $display("test m0_rx done");
    finish_test();
  end
endmodule
bind ubm_uart ubm_props u_props (.sys_clk_i, .rstn_i, .ctrl_i, .tx_done_clr_i,
  .rx_done_clr_i, .rxd_pin_oe_n_o, .txd_pin_o, .line_buffer_o, .tx_done_flag_o,
  .rx_done_flag_o, .tx_active_o, .rx_active_o);
`default_nettype wire
